/* File: rtl/buf_diag_pkg.sv */
// buffer write/read diagnostic command package: widths, codes, types
// assumes a single 50 MHz clock domain and a ten-byte command block
package buf_diag_pkg;

  // ----------------------------------------------------------------
  // buffer geometry
  // ----------------------------------------------------------------
  localparam int          BUF_BYTES = 16384;
  localparam int          ADDR_W    = 14;
  localparam int          LEN_W     = 24;
  localparam logic [23:0] BUF_CAP   = 24'(BUF_BYTES);
  localparam logic [2:0]  HDR_BYTES = 3'h4;
  localparam logic [23:0] COMB_LIMIT = BUF_CAP + 24'(HDR_BYTES);

  // ----------------------------------------------------------------
  // command block layout
  // ----------------------------------------------------------------
  localparam int BYTE_OPC  = 0;
  localparam int BYTE_CTL  = 1;
  localparam int BYTE_ID   = 2;
  localparam int BYTE_OFS  = 3;
  localparam int BYTE_LEN  = 6;
  localparam int BYTE_LINK = 9;
  localparam int LUN_LSB   = 5;
  localparam int MODE_LSB  = 0;
  localparam int FLAG_BIT  = 1;
  localparam int LINK_BIT  = 0;

  localparam logic [7:0] OP_WRITE_BUF = 8'h3B;
  localparam logic [7:0] OP_READ_BUF  = 8'h3C;

  localparam logic [1:0] MODE_COMBINED = 2'h0;
  localparam logic [1:0] MODE_RSVD     = 2'h1;
  localparam logic [1:0] MODE_DATA     = 2'h2;
  localparam logic [1:0] MODE_DESC     = 2'h3;

  // ----------------------------------------------------------------
  // completion status and sense keys
  // ----------------------------------------------------------------
  localparam logic [7:0] STS_GOOD  = 8'h00;
  localparam logic [7:0] STS_CHECK = 8'h02;
  localparam logic [7:0] STS_BUSY  = 8'h08;
  localparam logic [7:0] STS_RESV  = 8'h18;

  localparam logic [3:0] SK_NONE      = 4'h0;
  localparam logic [3:0] SK_NOT_READY = 4'h2;
  localparam logic [3:0] SK_HW_ERROR  = 4'h4;
  localparam logic [3:0] SK_ILLEGAL   = 4'h5;
  localparam logic [3:0] SK_UNIT_ATTN = 4'h6;
  localparam logic [3:0] SK_ABORTED   = 4'hB;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [0:9][7:0] cdb_type;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  lun;
    logic [1:0]  mode;
    logic [7:0]  buf_id;
    logic [23:0] offset;
    logic [23:0] length;
    logic        flag;
    logic        link;
  } cdb_fields_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [3:0] sense;
  } status_type;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_SEND} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic        desc;
    logic        zero_hdr;
    logic [2:0]  hdr_idx;
    logic [13:0] addr;
    logic [23:0] rem;
    logic        cdb_ready;
    logic        dout_ready;
    logic        din_valid;
    logic [7:0]  din_byte;
    status_type  sts;
  } ctl_type;

endpackage

/* File: rtl/cdb_decoder.sv */
// splits a ten-byte command block into its fields
// assumes the block is held stable while it is offered
`timescale 1ns/100ps
module cdb_decoder
  import buf_diag_pkg::*;
(
  input  wire cdb_type        cdb,
  output cdb_fields_type      fields
);

  // ----------------------------------------------------------------
  // field extraction
  // ----------------------------------------------------------------
  assign fields.opcode = cdb[BYTE_OPC];                         // R4
  assign fields.lun    = cdb[BYTE_CTL][LUN_LSB +: 3];           // R4
  assign fields.mode   = cdb[BYTE_CTL][MODE_LSB +: 2];          // R4
  assign fields.buf_id = cdb[BYTE_ID];                          // R4
  assign fields.offset = {cdb[BYTE_OFS], cdb[BYTE_OFS + 1],
                          cdb[BYTE_OFS + 2]};                   // R4
  assign fields.length = {cdb[BYTE_LEN], cdb[BYTE_LEN + 1],
                          cdb[BYTE_LEN + 2]};                   // R4
  assign fields.flag   = cdb[BYTE_LINK][FLAG_BIT];
  assign fields.link   = cdb[BYTE_LINK][LINK_BIT];

endmodule

/* File: rtl/buffer_ram.sv */
// byte-wide diagnostic data buffer, one write port, asynchronous read
// assumes a single address shared by reads and writes
`timescale 1ns/100ps
module buffer_ram #(
  parameter int DEPTH = 16384,
  parameter int AW    = 14
) (
  input  wire logic          clk,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic [7:0]         rdata
);

  logic [7:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];

endmodule

/* File: rtl/buf_diag_cmd.sv */
// buffer write/read diagnostic command interpreter, target side
// assumes command, data-out and data-in streams framed by the bus
// phase logic outside; one clock, synchronous reset, clock enable
//
// Summary of operation
// R1 - opcode 3BH in byte 0 is the buffer write command
// R2 - opcode 3CH in byte 0 is the buffer read command
// R3 - mode 0 combined, 2 data, 1 reserved, 3 reserved write/descriptor read
// R4 - fields: lun, mode, id, offset, length, flag and link bytes
// R5 - combined write: four-byte header first; id and offset ignored
// R6 - combined write: length includes header; store length minus four
// R7 - initiator uses length 4004H to fill the whole buffer
// R8 - combined write longer than buffer plus four: illegal request
// R9 - combined write header bytes are never checked
// R10 - data write with nonzero buffer id: illegal request
// R11 - data write stores length bytes starting at the offset
// R12 - data write with offset plus length past buffer: illegal request
// R13 - initiator keeps offset plus length inside the buffer
// R14 - combined read returns four-byte header then buffer data
// R15 - zero allocation length sends nothing; otherwise caps bytes sent
// R16 - combined read ends at allocation length or all available data
// R17 - data read with nonzero buffer id: illegal request
// R18 - data read sends from the offset, up to allocation length
// R19 - header available length is full buffer size, never reduced
// R20 - data after header: lesser of allocation minus four and available
// R21 - header: byte 0 reserved, bytes 1-3 available length msb first
// R22 - status good 00H, busy 08H, conflict 18H, check 02H
// R23 - check sets not ready, hw error, illegal, unit attention, aborted
// R24 - descriptor read: zero byte then 24-bit capacity; zeros if id set
// R25 - descriptor read never sends more than four bytes
// R26 - write with reserved mode 1 or 3: illegal request
// R27 - bound checks treat the buffer as 16384 bytes
`timescale 1ns/100ps
module buf_diag_cmd
  import buf_diag_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    srst,
  input  wire logic    ce,
  input  wire logic    cdb_valid,
  input  wire cdb_type cdb,
  output logic         cdb_ready,
  input  wire logic    other_busy,
  input  wire logic    resv_conflict,
  input  wire logic    unit_attn,
  input  wire logic    not_ready,
  input  wire logic    hw_fault,
  input  wire logic    abort_req,
  input  wire logic    dout_valid,
  input  wire logic [7:0] dout_byte,
  output logic         dout_ready,
  output logic         din_valid,
  output logic [7:0]   din_byte,
  input  wire logic    din_ready,
  output status_type   sts
);

  ctl_type        q;
  ctl_type        n;
  cdb_fields_type f;
  logic           ram_we;
  logic [7:0]     ram_rdata;
  logic           take_cdb;
  logic           accept;
  logic           advance;
  logic [24:0]    ofs_end;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  cdb_decoder u_dec (
    .cdb    (cdb),
    .fields (f)
  );

  buffer_ram #(
    .DEPTH (BUF_BYTES),
    .AW    (ADDR_W)
  ) u_ram (
    .clk   (clk),
    .ce    (ce),
    .we    (ram_we),
    .addr  (q.addr),
    .wdata (dout_byte),
    .rdata (ram_rdata)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] hdr_byte(input logic [2:0] idx,
                                          input logic       zero);
    logic [23:0] avail;
    avail = zero ? 24'h000000 : BUF_CAP;                        // R19
    unique case (idx)
      3'h1:    hdr_byte = avail[23:16];                         // R21
      3'h2:    hdr_byte = avail[15:8];
      3'h3:    hdr_byte = avail[7:0];
      default: hdr_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [23:0] min24(input logic [23:0] a,
                                        input logic [23:0] b);
    min24 = (a < b) ? a : b;
  endfunction

  assign take_cdb = cdb_valid && q.cdb_ready && (q.phase == ST_IDLE);
  assign accept   = dout_valid && q.dout_ready;
  assign advance  = !q.din_valid || din_ready;
  assign ofs_end  = {1'b0, f.offset} + {1'b0, f.length};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    n.sts.valid = 1'b0;
    ram_we = 1'b0;
    unique case (q.phase)
      ST_IDLE: begin
        n.cdb_ready = 1'b1;
        if (take_cdb) begin
          n.cdb_ready = 1'b0;
          n.sts = '{1'b1, STS_GOOD, SK_NONE};                   // R22
          n.desc = 1'b0;
          n.zero_hdr = 1'b0;
          n.addr = '0;
          n.hdr_idx = 3'h0;
          if (other_busy) begin
            n.sts.code = STS_BUSY;                              // R22
          end else if (resv_conflict) begin
            n.sts.code = STS_RESV;                              // R22
          end else if (unit_attn) begin
            n.sts = '{1'b1, STS_CHECK, SK_UNIT_ATTN};           // R23
          end else if (not_ready) begin
            n.sts = '{1'b1, STS_CHECK, SK_NOT_READY};           // R23
          end else if (hw_fault) begin
            n.sts = '{1'b1, STS_CHECK, SK_HW_ERROR};            // R23
          end else if (f.opcode == OP_WRITE_BUF) begin           // R1
            n.sts.valid = 1'b0;
            n.rem = f.length;
            unique case (f.mode)                                // R3
              MODE_COMBINED: begin                              // R5
                if (f.length > COMB_LIMIT) begin                // R8 R27
                  n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
                end
              end
              MODE_DATA: begin
                n.hdr_idx = HDR_BYTES;
                n.addr = f.offset[ADDR_W-1:0];                  // R11
                if (f.buf_id != 8'h00) begin                    // R10
                  n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
                end else if (ofs_end > 25'(BUF_CAP)) begin      // R12
                  n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
                end
              end
              default: begin
                n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};         // R26
              end
            endcase
            if (!n.sts.valid) begin
              if (f.length == 24'h000000) begin
                n.sts = '{1'b1, STS_GOOD, SK_NONE};
              end else begin
                n.phase = ST_RECV;
                n.dout_ready = 1'b1;
              end
            end
          end else if (f.opcode == OP_READ_BUF) begin            // R2
            n.sts.valid = 1'b0;
            unique case (f.mode)                                // R3
              MODE_COMBINED: begin                              // R14
                n.rem = min24(f.length, COMB_LIMIT);            // R16 R20
              end
              MODE_DATA: begin
                n.hdr_idx = HDR_BYTES;
                n.addr = f.offset[ADDR_W-1:0];                  // R18
                if (f.buf_id != 8'h00) begin                    // R17
                  n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
                end else if (f.offset > BUF_CAP) begin          // R27
                  n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
                end else begin
                  n.rem = min24(f.length, BUF_CAP - f.offset);  // R18
                end
              end
              MODE_DESC: begin
                n.desc = 1'b1;
                n.zero_hdr = (f.buf_id != 8'h00);               // R24
                n.rem = min24(f.length, 24'(HDR_BYTES));        // R25
              end
              default: begin
                n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
              end
            endcase
            if (!n.sts.valid) begin
              if (f.length == 24'h000000) begin                 // R15
                n.sts = '{1'b1, STS_GOOD, SK_NONE};
              end else begin
                n.phase = ST_SEND;
              end
            end
          end else begin
            n.sts = '{1'b1, STS_CHECK, SK_ILLEGAL};
          end
        end
      end
      ST_RECV: begin
        if (abort_req) begin
          n.dout_ready = 1'b0;
          n.phase = ST_IDLE;
          n.sts = '{1'b1, STS_CHECK, SK_ABORTED};               // R23
        end else if (accept) begin
          n.rem = q.rem - 24'h000001;
          if (q.hdr_idx < HDR_BYTES) begin
            n.hdr_idx = q.hdr_idx + 3'h1;                       // R9 R6
          end else begin
            ram_we = 1'b1;                                      // R6 R11
            n.addr = q.addr + 14'h0001;
          end
          if (q.rem == 24'h000001) begin
            n.dout_ready = 1'b0;
            n.phase = ST_IDLE;
            n.sts = '{1'b1, STS_GOOD, SK_NONE};
          end
        end
      end
      ST_SEND: begin
        if (abort_req) begin
          n.din_valid = 1'b0;
          n.phase = ST_IDLE;
          n.sts = '{1'b1, STS_CHECK, SK_ABORTED};               // R23
        end else if (advance) begin
          if (q.rem == 24'h000000) begin                        // R16
            n.din_valid = 1'b0;
            n.phase = ST_IDLE;
            n.sts = '{1'b1, STS_GOOD, SK_NONE};
          end else begin
            n.din_valid = 1'b1;
            n.rem = q.rem - 24'h000001;
            if (q.hdr_idx < HDR_BYTES) begin
              n.din_byte = hdr_byte(q.hdr_idx, q.zero_hdr);     // R14 R24
              n.hdr_idx = q.hdr_idx + 3'h1;
            end else begin
              n.din_byte = ram_rdata;                           // R18
              n.addr = q.addr + 14'h0001;
            end
          end
        end
      end
      default: begin
        n.phase = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '{phase: ST_IDLE, sts: '{1'b0, STS_GOOD, SK_NONE},
             default: '0};
    end else if (ce) begin
      q <= n;
    end
  end

  assign cdb_ready  = q.cdb_ready;
  assign dout_ready = q.dout_ready;
  assign din_valid  = q.din_valid;
  assign din_byte   = q.din_byte;
  assign sts        = q.sts;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] desc_cnt;
  logic       clean;

  assign clean = !other_busy && !resv_conflict && !unit_attn &&
                 !not_ready && !hw_fault;

  always_ff @(posedge clk) begin
    if (srst || q.phase == ST_IDLE) begin
      desc_cnt <= 4'h0;
    end else if (ce && q.desc && din_valid && din_ready) begin
      desc_cnt <= desc_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_busy;
    take_cdb && ce && other_busy |=> sts.valid && sts.code == STS_BUSY;
  endproperty
  a_busy: assert property (p_busy) else $error("busy status wrong"); // R22

  property p_wr_id;
    take_cdb && ce && clean && f.opcode == OP_WRITE_BUF &&
      f.mode == MODE_DATA && f.buf_id != 8'h00
      |=> sts.valid && sts.code == STS_CHECK && sts.sense == SK_ILLEGAL;
  endproperty
  a_wr_id: assert property (p_wr_id) else $error("write id check"); // R10

  property p_comb_len;
    take_cdb && ce && clean && f.opcode == OP_WRITE_BUF &&
      f.mode == MODE_COMBINED && f.length > 24'h004004
      |=> sts.valid && sts.code == STS_CHECK && sts.sense == SK_ILLEGAL;
  endproperty
  a_comb_len: assert property (p_comb_len) else $error("len check"); // R8

  property p_wr_rsvd;
    take_cdb && ce && clean && f.opcode == OP_WRITE_BUF && f.mode[0]
      |=> sts.valid && sts.sense == SK_ILLEGAL && q.phase == ST_IDLE;
  endproperty
  a_wr_rsvd: assert property (p_wr_rsvd) else $error("mode check"); // R26

  property p_zero_alloc;
    take_cdb && ce && clean && f.opcode == OP_READ_BUF &&
      f.mode == MODE_COMBINED && f.length == 24'h000000
      |=> sts.valid && sts.code == STS_GOOD && !din_valid;
  endproperty
  a_zero_alloc: assert property (p_zero_alloc) else $error("zero alloc"); // R15

  property p_hdr0;
    q.phase == ST_SEND && q.hdr_idx == 3'h1 && din_valid
      |-> din_byte == 8'h00;
  endproperty
  a_hdr0: assert property (p_hdr0) else $error("header byte 0"); // R21

  property p_desc_max;
    q.desc |-> desc_cnt <= 4'h4;
  endproperty
  a_desc_max: assert property (p_desc_max) else $error("desc overrun"); // R25

  property p_skip_hdr;
    accept && q.phase == ST_RECV && q.hdr_idx < 3'h4 |-> !ram_we;
  endproperty
  a_skip_hdr: assert property (p_skip_hdr) else $error("header stored"); // R6

  property p_store;
    ce && accept && q.phase == ST_RECV && q.hdr_idx == 3'h4 && !abort_req
      |-> ram_we ##1 (q.addr == $past(q.addr) + 14'h0001);
  endproperty
  a_store: assert property (p_store) else $error("data not stored"); // R11

  property p_last_rx;
    ce && accept && !abort_req && q.rem == 24'h000001
      |=> !dout_ready && sts.valid && sts.code == STS_GOOD;
  endproperty
  a_last_rx: assert property (p_last_rx) else $error("recv end"); // R6

  c_comb_wr: cover property (q.phase == ST_RECV && q.hdr_idx == 3'h0
                             ##[1:20] sts.valid);
  c_data_rd: cover property (q.phase == ST_SEND && q.hdr_idx == 3'h4
                             ##[1:20] sts.valid);
  c_desc_rd: cover property (q.desc ##[1:20] desc_cnt == 4'h4);

endmodule

/* File: testbench/host_model.sv */
// initiator model: offers command blocks, streams data out, sinks data in
// assumes registered target handshakes; drives only at the falling edge
`timescale 1ns/100ps
module host_model
  import buf_diag_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       cdb_ready,
  input  wire logic       dout_ready,
  input  wire logic       din_valid,
  input  wire logic [7:0] din_byte,
  input  wire status_type sts,
  output logic            cdb_valid,
  output cdb_type         cdb,
  output logic            dout_valid,
  output logic [7:0]      dout_byte,
  output logic            din_ready
);
  // ----------------------------------------------------------------
  // state seen by the bench
  // ----------------------------------------------------------------
  logic       slow;
  logic       got_sts;
  logic [7:0] sts_code;
  logic [3:0] sts_sense;
  logic [7:0] rx [$];

  initial begin
    slow       = 1'b0;
    got_sts    = 1'b0;
    cdb_valid  = 1'b0;
    cdb        = '0;
    dout_valid = 1'b0;
    dout_byte  = 8'h00;
    din_ready  = 1'b0;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + (i >>> 8));
  endfunction

  // ----------------------------------------------------------------
  // data-in sink and status capture
  // ----------------------------------------------------------------
  always @(negedge clk) din_ready <= slow ? ~din_ready : 1'b1;

  always @(posedge clk) begin
    if (din_valid === 1'b1 && din_ready === 1'b1) rx.push_back(din_byte);
    if (sts.valid === 1'b1) begin
      got_sts   <= 1'b1;
      sts_code  <= sts.code;
      sts_sense <= sts.sense;
    end
  end

  // ----------------------------------------------------------------
  // command, data-out and status wait tasks
  // ----------------------------------------------------------------
  task automatic cmd(input logic [7:0] op, input logic [1:0] mode,
                     input logic [7:0] id, input logic [23:0] ofs,
                     input logic [23:0] len);
    int n;
    @(negedge clk);
    got_sts = 1'b0;
    rx.delete();
    cdb = '0;
    cdb[0] = op;
    cdb[1] = {6'h00, mode};
    cdb[2] = id;
    {cdb[3], cdb[4], cdb[5]} = ofs;
    {cdb[6], cdb[7], cdb[8]} = len;
    cdb_valid = 1'b1;
    n = 0;
    while (cdb_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cdb_valid = 1'b0;
    cdb = ~cdb;
  endtask

  // combined mode: caller counts the four header bytes in n
  task automatic put_bytes(input int n, input int base);
    int i;
    i = 0;
    while (i < n && got_sts !== 1'b1) begin
      @(negedge clk);
      dout_valid = 1'b1;
      dout_byte = pat(base + i);
      if (dout_ready === 1'b1) i++;
    end
    @(negedge clk);
    dout_valid = 1'b0;
    dout_byte = ~dout_byte;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (got_sts !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule

/* File: testbench/tb_buf_diag_cmd.sv */
// self-checking bench for the buffer diagnostic command interpreter
// assumes host_model on the far side; 50 MHz clock, sync reset
`timescale 1ns/100ps
module tb_buf_diag_cmd;
  import buf_diag_pkg::*;
  logic       clk;
  logic       srst;
  logic       ce;
  logic [5:0] cond;
  logic       cdb_valid;
  cdb_type    cdb;
  logic       cdb_ready;
  logic       dout_valid;
  logic [7:0] dout_byte;
  logic       dout_ready;
  logic       din_valid;
  logic [7:0] din_byte;
  logic       din_ready;
  status_type sts;
  int         err_count;
  int         checked;
  logic [7:0] code_t [6];
  logic [31:0] hdr;

  buf_diag_cmd i_buf_diag_cmd (.clk(clk), .srst(srst), .ce(ce),
    .cdb_valid(cdb_valid), .cdb(cdb), .cdb_ready(cdb_ready),
    .other_busy(cond[0]), .resv_conflict(cond[1]), .unit_attn(cond[2]),
    .not_ready(cond[3]), .hw_fault(cond[4]), .abort_req(cond[5]),
    .dout_valid(dout_valid), .dout_byte(dout_byte),
    .dout_ready(dout_ready), .din_valid(din_valid), .din_byte(din_byte),
    .din_ready(din_ready), .sts(sts));

  host_model i_host_model (.clk(clk), .cdb_ready(cdb_ready),
    .dout_ready(dout_ready), .din_valid(din_valid), .din_byte(din_byte),
    .sts(sts), .cdb_valid(cdb_valid), .cdb(cdb), .dout_valid(dout_valid),
    .dout_byte(dout_byte), .din_ready(din_ready));

  // ----------------------------------------------------------------
  // clock, compare and closing tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [23:0] seen,
                       input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic sts_is(input logic [7:0] code, input logic [3:0] sk);
    i_host_model.wait_done();
    check("sts_seen", 24'(i_host_model.got_sts), 24'h1);
    check("status", 24'(i_host_model.sts_code), 24'(code));
    if (code == STS_CHECK)
      check("sense", 24'(i_host_model.sts_sense), 24'(sk));
  endtask

  task automatic rx_data(input int at, input int n, input int base);
    for (int i = 0; i < n; i++)
      check("rx_data", 24'(i_host_model.rx[at + i]),
            24'(i_host_model.pat(base + i)));
  endtask

  task automatic rx_hdr(input logic [31:0] h);
    for (int j = 0; j < 4; j++)
      check("rx_hdr", 24'(i_host_model.rx[j]), 24'(h[31 - 8 * j -: 8]));
  endtask

  task automatic bad(input logic [7:0] op, input logic [1:0] mode,
                     input logic [7:0] id, input logic [23:0] ofs,
                     input logic [23:0] len);
    i_host_model.cmd(op, mode, id, ofs, len);
    sts_is(STS_CHECK, SK_ILLEGAL);
    check("rx_count", 24'(i_host_model.rx.size()), 24'h000000);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    err_count = 0;
    checked = 0;
    srst = 1'b1;
    ce = 1'b1;
    cond = 6'h00;
    code_t = '{STS_BUSY, STS_RESV, STS_CHECK, STS_CHECK, STS_CHECK,
               STS_CHECK};
    hdr = {8'h00, BUF_CAP};
    repeat (6) @(negedge clk);
    srst = 1'b0;
    // full combined write, then tail read with a stalling sink
    i_host_model.cmd(OP_WRITE_BUF, MODE_COMBINED, 8'h00, 24'h0,
                     24'h004004);
    i_host_model.put_bytes(16388, 200);
    sts_is(STS_GOOD, SK_NONE);
    i_host_model.slow = 1'b1;
    i_host_model.cmd(OP_READ_BUF, MODE_DATA, 8'h00, 24'h003FFE, 24'h8);
    sts_is(STS_GOOD, SK_NONE);
    check("rx_count", 24'(i_host_model.rx.size()), 24'h2);
    rx_data(0, 2, 204 + 16382);
    i_host_model.slow = 1'b0;
    // data mode write and read back at an offset
    i_host_model.cmd(OP_WRITE_BUF, MODE_DATA, 8'h00, 24'h10, 24'h5);
    i_host_model.put_bytes(5, 100);
    sts_is(STS_GOOD, SK_NONE);
    i_host_model.cmd(OP_READ_BUF, MODE_DATA, 8'h00, 24'h10, 24'h5);
    sts_is(STS_GOOD, SK_NONE);
    rx_data(0, 5, 100);
    // combined write of 8 data bytes, combined read of 10
    i_host_model.cmd(OP_WRITE_BUF, MODE_COMBINED, 8'h00, 24'h0, 24'hC);
    i_host_model.put_bytes(12, 0);
    sts_is(STS_GOOD, SK_NONE);
    i_host_model.cmd(OP_READ_BUF, MODE_COMBINED, 8'h00, 24'h0, 24'hA);
    sts_is(STS_GOOD, SK_NONE);
    check("rx_count", 24'(i_host_model.rx.size()), 24'hA);
    rx_hdr(hdr);
    rx_data(4, 6, 4);
    i_host_model.cmd(OP_READ_BUF, MODE_COMBINED, 8'h00, 24'h0, 24'h0);
    sts_is(STS_GOOD, SK_NONE);
    check("rx_count", 24'(i_host_model.rx.size()), 24'h0);
    // descriptor reads
    i_host_model.cmd(OP_READ_BUF, MODE_DESC, 8'h00, 24'h0, 24'h9);
    sts_is(STS_GOOD, SK_NONE);
    check("rx_count", 24'(i_host_model.rx.size()), 24'h4);
    rx_hdr(hdr);
    i_host_model.cmd(OP_READ_BUF, MODE_DESC, 8'h05, 24'h0, 24'h9);
    sts_is(STS_GOOD, SK_NONE);
    rx_hdr(32'h0);
    // last byte of the buffer is a legal data write
    i_host_model.cmd(OP_WRITE_BUF, MODE_DATA, 8'h00, 24'h003FFF, 24'h1);
    i_host_model.put_bytes(1, 7);
    sts_is(STS_GOOD, SK_NONE);
    // refused commands
    bad(OP_WRITE_BUF, MODE_RSVD, 8'h00, 24'h0, 24'h4);
    bad(OP_WRITE_BUF, MODE_DESC, 8'h00, 24'h0, 24'h4);
    bad(OP_WRITE_BUF, MODE_DATA, 8'h01, 24'h0, 24'h4);
    bad(OP_WRITE_BUF, MODE_DATA, 8'h00, 24'h003FFF, 24'h2);
    bad(OP_READ_BUF, MODE_DATA, 8'h01, 24'h0, 24'h4);
    bad(OP_WRITE_BUF, MODE_COMBINED, 8'h00, 24'h0, 24'h004005);
    bad(OP_READ_BUF, MODE_RSVD, 8'h00, 24'h0, 24'h4);
    bad(8'h3D, MODE_COMBINED, 8'h00, 24'h0, 24'h4);
    // condition inputs, one at a time
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      cond = 6'(1 << k);
      i_host_model.cmd(OP_READ_BUF, MODE_DESC, 8'h00, 24'h0, 24'h4);
      sts_is(code_t[k], k == 2 ? SK_UNIT_ATTN : k == 3 ? SK_NOT_READY :
                        k == 4 ? SK_HW_ERROR : SK_ABORTED);
      @(negedge clk);
      cond = 6'h00;
    end
    // abort in mid data-out
    i_host_model.cmd(OP_WRITE_BUF, MODE_DATA, 8'h00, 24'h0, 24'h6);
    fork
      begin
        repeat (3) @(negedge clk);
        cond = 6'h20;
      end
      i_host_model.put_bytes(6, 50);
    join
    sts_is(STS_CHECK, SK_ABORTED);
    @(negedge clk);
    cond = 6'h00;
    // frozen clock enable: an offered read is never taken
    ce = 1'b0;
    i_host_model.cmd(OP_READ_BUF, MODE_DESC, 8'h00, 24'h0, 24'h4);
    repeat (3) @(negedge clk);
    check("ce_hold", 24'({i_host_model.got_sts, cdb_ready, din_valid}),
          24'h2);
    ce = 1'b1;
    results();
  end
endmodule
